// File: src/rsbc_top.sv
// reset sequencing, voltage-drop reset and RAM back-up control
//
// Added by the designer: the Wishbone register port and the register addresses.
module rsbc_top #(
   parameter int HOLD_CYC = rsbc_pkg::RSBC_HOLD_CYC
) (
   // clock and reset
   input  wire logic                           clk_i,
   input  wire logic                           rst_i,
   // wishbone slave
   input  wire logic                           wb_cyc_i,
   input  wire logic                           wb_stb_i,
   input  wire logic                           wb_we_i,
   input  wire logic [3:0]                     wb_adr_i,
   input  wire logic [3:0]                     wb_sel_i,
   input  wire logic [31:0]                    wb_dat_i,
   output logic      [31:0]                    wb_dat_o,
   output logic                                wb_ack_o,
   // instruction execution from the core
   input  wire logic                           instr_valid_i,
   input  wire rsbc_pkg::rsbc_instr_e          instr_code_i,
   input  wire logic                           watchdog_rst_i,
   output logic                                skip_o,
   // pins and supply monitor
   input  wire logic                           reset_pin_i,
   output logic                                reset_pin_o,
   output logic                                reset_pin_oe_o,
   input  wire logic                           wakeup_i,
   input  wire logic                           supply_low_i,
   // core control
   output logic                                core_reset_o,
   output logic [rsbc_pkg::RSBC_PC_W-1:0]      pc_start_o,
   output logic                                osc_run_o,
   output logic                                backup_o,
   output logic                                power_down_flag_o,
   output logic                                prescaler_ctl_o,
   output logic [3:0]                          timer_ctl_five_o,
   output logic [3:0]                          timer_ctl_six_o,
   output logic [3:0]                          clock_mode_bits_o,
   output logic                                oscillator_stop_ctl_o
);
   import rsbc_pkg::*;

   localparam int CNT_W = $clog2(HOLD_CYC + RSBC_PIN_DRIVE_CYC + 8);
   localparam logic [CNT_W-1:0] DRIVE_END =
      CNT_W'(RSBC_PIN_DRIVE_CYC);
   localparam logic [CNT_W-1:0] SETTLE_END =
      CNT_W'(RSBC_PIN_DRIVE_CYC + RSBC_SYNC_LAT_CYC);
   localparam logic [CNT_W-1:0] HOLD_END = CNT_W'(HOLD_CYC);

   rsbc_state_e      state_reg;
   rsbc_state_e      state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic             drive_reg;
   logic             pdf_reg;
   logic             keep_reg;
   logic             arm_reg;
   logic             ack_reg;
   logic [31:0]      rdat_reg;
   logic             presc_reg;
   logic             osc_reg;
   logic [3:0]       five_reg;
   logic [3:0]       six_reg;
   logic [3:0]       clkmd_reg;
   logic [RSBC_PC_W-1:0] pc_reg;
   logic             pin_lvl;
   logic             wake_lvl;
   logic             low_lvl;
   logic             ins_keep;
   logic             ins_arm;
   logic             ins_enter;
   logic             ins_sysrst;
   logic             go_backup;
   logic             vd_active;
   logic             vd_trip;
   logic             drive_req;
   logic             cold_evt;
   logic             wake_evt;
   logic             sys_init;
   logic             wb_req;
   logic             wb_wr;

   // pin and supply synchronisers
   rsbc_sync #(.RST_VAL(1'h1)) u_pin_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (reset_pin_i),
      .level_o (pin_lvl)
   );
   rsbc_sync #(.RST_VAL(1'h0)) u_wake_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (wakeup_i),
      .level_o (wake_lvl)
   );
   rsbc_sync #(.RST_VAL(1'h0)) u_low_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (supply_low_i),
      .level_o (low_lvl)
   );

   // instruction decode, only while the core runs
   always_comb begin
      ins_keep   = 1'b0;
      ins_arm    = 1'b0;
      ins_enter  = 1'b0;
      ins_sysrst = 1'b0;
      if (instr_valid_i && state_reg == RSBC_ST_RUN) begin
         ins_keep   = (instr_code_i == RSBC_INS_KEEP);
         ins_arm    = (instr_code_i == RSBC_INS_ARM);
         ins_enter  = (instr_code_i == RSBC_INS_ENTER);
         ins_sysrst = (instr_code_i == RSBC_INS_SYSRST);
      end
   end

   // enter only right after arm, else a plain nop
   assign go_backup = ins_enter && arm_reg;

   // detector validity and trip
   assign vd_active = (state_reg != RSBC_ST_BACKUP) || keep_reg;
   assign vd_trip   = vd_active && low_lvl;
   assign drive_req = vd_trip || ins_sysrst;

   // cold sources: pin, instruction, watchdog, detector
   assign cold_evt = !pin_lvl || drive_req
                     || (watchdog_rst_i && state_reg == RSBC_ST_RUN);
   assign wake_evt = (state_reg == RSBC_ST_BACKUP) && wake_lvl;
   assign sys_init = rst_i
                     || (state_reg != RSBC_ST_HOLD && cold_evt);

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RSBC_ST_RUN: begin
            if (cold_evt) begin
               state_next = RSBC_ST_HOLD;
            end else if (go_backup) begin
               state_next = RSBC_ST_BACKUP;
            end
         end
         RSBC_ST_HOLD: begin
            if (cnt_reg >= HOLD_END && cnt_reg >= SETTLE_END && pin_lvl)
            begin
               state_next = RSBC_ST_RUN;
            end
         end
         RSBC_ST_BACKUP: begin
            if (cold_evt || wake_evt) begin
               state_next = RSBC_ST_HOLD;
            end
         end
         default: state_next = RSBC_ST_HOLD;
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= RSBC_ST_HOLD;
      end else begin
         state_reg <= state_next;
      end
   end

   // hold counter, held at SETTLE_END while the pin is still seen low
   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg != RSBC_ST_HOLD) begin
         cnt_reg <= '0;
      end else if (!pin_lvl && cnt_reg >= SETTLE_END) begin
         cnt_reg <= SETTLE_END;
      end else if (cnt_reg < HOLD_END || cnt_reg < SETTLE_END) begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // open-drain pull of the reset line for detector trip and reset instruction, not watchdog
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_reg <= 1'b0;
      end else if (state_reg != RSBC_ST_HOLD && drive_req) begin
         drive_reg <= 1'b1;
      end else if (cnt_reg >= DRIVE_END - CNT_W'(1)) begin
         drive_reg <= 1'b0;
      end
   end

   // power down flag
   always_ff @(posedge clk_i) begin
      if (sys_init) begin
         pdf_reg <= 1'b0;
      end else if (wake_evt) begin
         pdf_reg <= 1'b1;
      end
   end

   // write-once detector keep latch
   always_ff @(posedge clk_i) begin
      if (sys_init) begin
         keep_reg <= 1'b0;
      end else if (ins_keep && !keep_reg) begin
         keep_reg <= 1'b1;
      end
   end

   // arm lasts for exactly the next instruction
   always_ff @(posedge clk_i) begin
      if (sys_init || state_reg != RSBC_ST_RUN) begin
         arm_reg <= 1'b0;
      end else if (instr_valid_i) begin
         arm_reg <= ins_arm;
      end
   end

   // program counter start address, forced on every reset
   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg == RSBC_ST_HOLD) begin
         pc_reg <= RSBC_PC_RST;
      end
   end

   // wishbone handshake
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wb_req;
      end
   end

   // prescaler and oscillator controls; warm start also reinitialises
   always_ff @(posedge clk_i) begin
      if (sys_init || wake_evt) begin
         presc_reg <= RSBC_PRESC_RST;
         osc_reg   <= RSBC_OSC_RST;
      end else if (wb_wr && wb_adr_i == RSBC_OFS_CTRL) begin
         presc_reg <= wb_dat_i[RSBC_CTRL_PRESC_BIT];
         osc_reg   <= wb_dat_i[RSBC_CTRL_OSC_BIT];
      end
   end

   // timer controls five and six survive back-up
   always_ff @(posedge clk_i) begin
      if (sys_init) begin
         five_reg <= RSBC_TMR_RST;
         six_reg  <= RSBC_TMR_RST;
      end else if (wb_wr && wb_adr_i == RSBC_OFS_TIMER) begin
         five_reg <= wb_dat_i[RSBC_TMR_FIVE_LSB +: 4];
         six_reg  <= wb_dat_i[RSBC_TMR_SIX_LSB +: 4];
      end
   end

   // clock mode bits
   always_ff @(posedge clk_i) begin
      if (sys_init || wake_evt) begin
         clkmd_reg <= RSBC_CLKMD_RST;
      end else if (wb_wr && wb_adr_i == RSBC_OFS_CLKMD) begin
         clkmd_reg <= wb_dat_i[3:0];
      end
   end

   // read data; unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_reg <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         rdat_reg <= 32'h0000_0000;
         case (wb_adr_i)
            RSBC_OFS_CTRL: begin
               rdat_reg[RSBC_CTRL_PRESC_BIT] <= presc_reg;
               rdat_reg[RSBC_CTRL_OSC_BIT]   <= osc_reg;
            end
            RSBC_OFS_TIMER: begin
               rdat_reg[RSBC_TMR_FIVE_LSB +: 4] <= five_reg;
               rdat_reg[RSBC_TMR_SIX_LSB +: 4]  <= six_reg;
            end
            RSBC_OFS_CLKMD: begin
               rdat_reg[3:0] <= clkmd_reg;
            end
            RSBC_OFS_STATUS: begin
               rdat_reg[RSBC_ST_PDF_BIT]    <= pdf_reg;
               rdat_reg[RSBC_ST_KEEP_BIT]   <= keep_reg;
               rdat_reg[RSBC_ST_ARM_BIT]    <= arm_reg;
               rdat_reg[RSBC_ST_BACKUP_BIT] <= backup_o;
               rdat_reg[RSBC_ST_VDACT_BIT]  <= vd_active;
            end
            default: rdat_reg <= 32'h0000_0000;
         endcase
      end
   end

   // skip test on the power down flag
   assign skip_o = instr_valid_i && state_reg == RSBC_ST_RUN
                   && instr_code_i == RSBC_INS_SKIPW && pdf_reg;

   // outputs
   assign wb_ack_o              = ack_reg;
   assign wb_dat_o              = rdat_reg;
   assign reset_pin_o           = 1'b0;
   assign reset_pin_oe_o        = drive_reg;
   assign core_reset_o          = (state_reg == RSBC_ST_HOLD);
   assign pc_start_o            = pc_reg;
   assign backup_o              = (state_reg == RSBC_ST_BACKUP);
   assign osc_run_o             = !backup_o;
   assign power_down_flag_o     = pdf_reg;
   assign prescaler_ctl_o       = presc_reg;
   assign timer_ctl_five_o      = five_reg;
   assign timer_ctl_six_o       = six_reg;
   assign clock_mode_bits_o     = clkmd_reg;
   assign oscillator_stop_ctl_o = osc_reg;
   // other state is not initialised here, software sets it
endmodule

// File: src/rsbc_pkg.sv
package rsbc_pkg;

   // wishbone register byte offsets
   localparam logic [3:0] RSBC_OFS_CTRL   = 4'h0;
   localparam logic [3:0] RSBC_OFS_TIMER  = 4'h4;
   localparam logic [3:0] RSBC_OFS_CLKMD  = 4'h8;
   localparam logic [3:0] RSBC_OFS_STATUS = 4'hC;

   // ctrl register fields
   localparam int RSBC_CTRL_PRESC_BIT = 0;
   localparam int RSBC_CTRL_OSC_BIT   = 1;
   // timer register fields
   localparam int RSBC_TMR_FIVE_LSB   = 0;
   localparam int RSBC_TMR_SIX_LSB    = 4;
   // status register fields
   localparam int RSBC_ST_PDF_BIT     = 0;
   localparam int RSBC_ST_KEEP_BIT    = 1;
   localparam int RSBC_ST_ARM_BIT     = 2;
   localparam int RSBC_ST_BACKUP_BIT  = 3;
   localparam int RSBC_ST_VDACT_BIT   = 4;

   // reset values
   localparam logic       RSBC_PRESC_RST = 1'h0;
   localparam logic [3:0] RSBC_TMR_RST   = 4'h0;
   localparam logic [3:0] RSBC_CLKMD_RST = 4'hD;
   localparam logic       RSBC_OSC_RST   = 1'h0;
   localparam int         RSBC_PC_W      = 11;
   localparam logic [RSBC_PC_W-1:0] RSBC_PC_RST = 11'h000;

   // timing counts in clock cycles
   localparam int RSBC_PIN_DRIVE_CYC = 4;
   localparam int RSBC_SYNC_LAT_CYC  = 3;
   localparam int RSBC_HOLD_CYC      = 120;

   // instruction codes from the core decoder
   typedef enum logic [2:0] {
      RSBC_INS_OTHER  = 3'h0,
      RSBC_INS_KEEP   = 3'h1,
      RSBC_INS_ARM    = 3'h2,
      RSBC_INS_ENTER  = 3'h3,
      RSBC_INS_SKIPW  = 3'h4,
      RSBC_INS_SYSRST = 3'h5
   } rsbc_instr_e;

   // sequencer states
   typedef enum logic [2:0] {
      RSBC_ST_RUN    = 3'h1,
      RSBC_ST_HOLD   = 3'h2,
      RSBC_ST_BACKUP = 3'h4
   } rsbc_state_e;

endpackage

// File: src/rsbc_sync.sv
// three-stage input synchroniser; output follows once stages two and three agree
module rsbc_sync #(
   parameter logic RST_VAL = 1'h1
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // asynchronous input and filtered level
   input  wire logic async_i,
   output logic      level_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic lvl_reg;

   // shift chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
      end else begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // agreement filter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_reg <= RST_VAL;
      end else if (s2_reg == s3_reg) begin
         lvl_reg <= s3_reg;
      end
   end

   assign level_o = lvl_reg;
endmodule

// File: testbench/rsbc_assertions.sv
// port-level checks for the reset and back-up sequencer
module rsbc_chk (
   // clock, reset and bus
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_ack_o,
   // instructions and sources
   input wire logic                   instr_valid_i,
   input wire rsbc_pkg::rsbc_instr_e  instr_code_i,
   input wire logic                   watchdog_rst_i,
   input wire logic                   supply_low_i,
   input wire logic                   wakeup_i,
   // observed outputs
   input wire logic                   skip_o,
   input wire logic                   reset_pin_o,
   input wire logic                   reset_pin_oe_o,
   input wire logic                   core_reset_o,
   input wire logic [10:0]            pc_start_o,
   input wire logic                   osc_run_o,
   input wire logic                   backup_o,
   input wire logic                   power_down_flag_o,
   input wire logic [3:0]             clock_mode_bits_o
);
   import rsbc_pkg::*;
   logic run;
   logic armed_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // cpu running, neither held nor backed up
   assign run = !core_reset_o && !backup_o;
   // pending arm, dropped by any other executed instruction
   always_ff @(posedge clk_i) begin
      if (rst_i || !run)
         armed_reg <= 1'b0;
      else if (instr_valid_i)
         armed_reg <= (instr_code_i == RSBC_INS_ARM);
   end
   sequence s_enter;
      instr_valid_i && instr_code_i == RSBC_INS_ENTER && run;
   endsequence
   sequence s_wake;
      backup_o && wakeup_i && !supply_low_i;
   endsequence
   AST_RST_STATE: assert property (disable iff (1'b0)
      rst_i |=> pc_start_o == 11'h000 && clock_mode_bits_o == 4'hD
      && !power_down_flag_o && core_reset_o) else $error("reset state");
   AST_ENTER: assert property (
      s_enter ##0 armed_reg && !supply_low_i && !watchdog_rst_i
      |=> backup_o) else $error("armed enter ignored");
   AST_NOARM: assert property (
      s_enter ##0 !armed_reg |=> !backup_o) else $error("enter not a nop");
   AST_WAKE: assert property (
      s_wake |-> ##[1:8] core_reset_o && power_down_flag_o
      && pc_start_o == 11'h000) else $error("warm start wrong");
   AST_VDROP: assert property (
      supply_low_i && run |-> ##[1:8] core_reset_o && !power_down_flag_o)
      else $error("drop reset missing");
   AST_WDOG: assert property (
      watchdog_rst_i && run |-> ##[1:4] core_reset_o && !power_down_flag_o)
      else $error("watchdog reset missing");
   AST_PIN: assert property (
      reset_pin_oe_o |-> !reset_pin_o && core_reset_o)
      else $error("pin drive wrong");
   AST_BACKUP: assert property (
      backup_o |-> !osc_run_o && !core_reset_o) else $error("osc in backup");
   AST_SKIP: assert property (
      instr_valid_i && instr_code_i == RSBC_INS_SKIPW && run
      |-> skip_o == power_down_flag_o) else $error("skip wrong");
   AST_ACK: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing");
endmodule
bind rsbc_top rsbc_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .instr_valid_i(instr_valid_i), .instr_code_i(instr_code_i),
   .watchdog_rst_i(watchdog_rst_i), .supply_low_i(supply_low_i),
   .wakeup_i(wakeup_i), .skip_o(skip_o), .reset_pin_o(reset_pin_o),
   .reset_pin_oe_o(reset_pin_oe_o), .core_reset_o(core_reset_o),
   .pc_start_o(pc_start_o), .osc_run_o(osc_run_o), .backup_o(backup_o),
   .power_down_flag_o(power_down_flag_o),
   .clock_mode_bits_o(clock_mode_bits_o)
);

// File: testbench/tb_reset_state_and_ram_backup_ctl.sv
module tb_reset_state_and_ram_backup_ctl;
   timeunit 1ns;
   timeprecision 100ps;
   import rsbc_pkg::*;
   localparam int HOLD = 8;
   logic clk_i = 1'b0;
   logic rst_i, cyc, stb, we, ack, vld, wdog, ext_pin, wake, slow;
   logic [3:0] adr, t5, t6, cm;
   logic [31:0] wdat, rdat, q;
   logic [10:0] pc;
   logic skip, pin_o, pin_oe, core_rst, osc_run, bkp, pflag, presc, oscst;
   logic skip_seen, oe_seen;
   rsbc_instr_e code;
   wire pin;
   int fails, checks, cyc_cnt;
   // clock and pin wire with the board's pull-up
   always #5 clk_i = ~clk_i;
   assign pin = pin_oe ? pin_o : ext_pin;
   rsbc_top #(.HOLD_CYC(HOLD)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .instr_valid_i(vld),
      .instr_code_i(code), .watchdog_rst_i(wdog), .skip_o(skip),
      .reset_pin_i(pin), .reset_pin_o(pin_o), .reset_pin_oe_o(pin_oe),
      .wakeup_i(wake), .supply_low_i(slow), .core_reset_o(core_rst),
      .pc_start_o(pc), .osc_run_o(osc_run), .backup_o(bkp),
      .power_down_flag_o(pflag), .prescaler_ctl_o(presc),
      .timer_ctl_five_o(t5), .timer_ctl_six_o(t6),
      .clock_mode_bits_o(cm), .oscillator_stop_ctl_o(oscst));
   task automatic close_out();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      chk(ack === 1'b1, "no bus ack");
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] mk,
                        input logic [31:0] e, input string m);
      wb(1'b0, a, 32'h0);
      chk((q & mk) === e, m);
   endtask
   // one executed instruction, skip sampled mid-cycle
   task automatic ins(input rsbc_instr_e c);
      @(posedge clk_i);
      vld <= 1'b1;
      code <= c;
      @(negedge clk_i);
      skip_seen = skip;
      @(posedge clk_i);
      vld <= 1'b0;
   endtask
   task automatic wait_run();
      for (int n = 0; n < 300 && !(core_rst === 1'b0 && bkp === 1'b0); n++)
         @(negedge clk_i);
      chk(core_rst === 1'b0 && bkp === 1'b0, "not running");
   endtask
   task automatic wait_hold();
      for (int n = 0; n < 30 && core_rst !== 1'b1; n++)
         @(negedge clk_i);
      chk(core_rst === 1'b1, "no reset hold");
   endtask
   task automatic enter_bk();
      ins(RSBC_INS_ARM);
      ins(RSBC_INS_ENTER);
      @(negedge clk_i);
      chk(bkp === 1'b1 && osc_run === 1'b0, "backup entry");
   endtask
   // hang guard and pin-drive monitor
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (pin_oe === 1'b1)
         oe_seen <= 1'b1;
      if (cyc_cnt == 5000) begin
         fails++;
         $display("CHECK FAILED at %0t: timeout", $time);
         close_out();
      end
   end
   initial begin
      {cyc, stb, we, vld, wdog, wake, slow, oe_seen} <= 8'h00;
      {rst_i, ext_pin} <= 2'h3;
      adr <= 4'h0;
      wdat <= 32'h0;
      code <= RSBC_INS_OTHER;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk(pc === 11'h000 && core_rst === 1'b1, "pc at reset");
      chk(presc === 1'b0 && oscst === 1'b0, "ctl at reset");
      chk(t5 === 4'h0 && t6 === 4'h0, "timers at reset");
      chk(cm === 4'hD && pflag === 1'b0, "mode at reset");
      $display("test reset values done");
      wb(1'b1, RSBC_OFS_TIMER, 32'h0000_00A5);
      wb(1'b1, RSBC_OFS_CTRL, 32'h0000_0003);
      wb(1'b1, RSBC_OFS_CLKMD, 32'h0000_0002);
      rdchk(RSBC_OFS_TIMER, 32'hFF, 32'hA5, "timer readback");
      rdchk(4'h2, 32'hFFFF_FFFF, 32'h0, "unmapped read");
      chk(t5 === 4'h5 && t6 === 4'hA && presc && oscst, "reg outputs");
      $display("test registers done");
      wait_run();
      ins(RSBC_INS_ENTER);
      @(negedge clk_i);
      chk(bkp === 1'b0, "lone enter");
      ins(RSBC_INS_KEEP);
      ins(RSBC_INS_KEEP);
      rdchk(RSBC_OFS_STATUS, 32'h2, 32'h2, "keep latch");
      ins(RSBC_INS_ARM);
      ins(RSBC_INS_OTHER);
      ins(RSBC_INS_ENTER);
      @(negedge clk_i);
      chk(bkp === 1'b0, "stale arm");
      $display("test arm sequence done");
      enter_bk();
      @(posedge clk_i);
      wake <= 1'b1;
      wait_hold();
      chk(pflag === 1'b1 && pc === 11'h000, "warm start");
      @(posedge clk_i);
      wake <= 1'b0;
      wait_run();
      chk(cm === 4'hD && !presc && !oscst && t5 === 4'h5, "warm state");
      ins(RSBC_INS_SKIPW);
      chk(skip_seen === 1'b1, "skip on warm");
      rdchk(RSBC_OFS_STATUS, 32'h3, 32'h3, "flags after warm");
      $display("test warm start done");
      enter_bk();
      oe_seen = 1'b0;
      @(posedge clk_i);
      slow <= 1'b1;
      wait_hold();
      chk(pflag === 1'b0 && bkp === 1'b0, "drop in backup");
      @(posedge clk_i);
      slow <= 1'b0;
      wait_run();
      chk(oe_seen === 1'b1, "pin not pulled");
      rdchk(RSBC_OFS_STATUS, 32'h3, 32'h0, "keep cleared");
      enter_bk();
      @(posedge clk_i);
      slow <= 1'b1;
      repeat (20) @(negedge clk_i);
      chk(bkp === 1'b1 && core_rst === 1'b0, "drop ignored");
      @(posedge clk_i);
      slow <= 1'b0;
      repeat (6) @(posedge clk_i);
      wake <= 1'b1;
      wait_hold();
      @(posedge clk_i);
      wake <= 1'b0;
      wait_run();
      $display("test voltage drop done");
      oe_seen = 1'b0;
      ins(RSBC_INS_SYSRST);
      wait_hold();
      wait_run();
      chk(pflag === 1'b0 && oe_seen === 1'b1, "reset instr");
      ins(RSBC_INS_SKIPW);
      chk(skip_seen === 1'b0, "skip on cold");
      @(posedge clk_i);
      wdog <= 1'b1;
      wait_hold();
      chk(pflag === 1'b0 && pc === 11'h000, "watchdog");
      @(posedge clk_i);
      wdog <= 1'b0;
      wait_run();
      @(posedge clk_i);
      slow <= 1'b1;
      wait_hold();
      chk(pflag === 1'b0 && pin_oe === 1'b1, "drop running");
      @(posedge clk_i);
      slow <= 1'b0;
      wait_run();
      $display("test cold sources done");
      close_out();
   end
endmodule
